// ==== include/ipr_map.svh ====
/*
 Register map, field positions, reset values and widths of the interrupt
 priority block. Assumes it is included by bare name wherever a number is needed.
*/
`ifndef IPR_MAP_SVH
`define IPR_MAP_SVH

// ----------------------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------------------
`define IPR_ADDR_W 8
`define IPR_DATA_W 8
`define IPR_PRIO_ADDR 8'hB8
`define IPR_RD_IDLE 8'h00

// ----------------------------------------------------------------------------
// Priority register fields
// ----------------------------------------------------------------------------
`define IPR_NSRC 6
`define IPR_ID_W 3
`define IPR_X0_BIT 0
`define IPR_T0_BIT 1
`define IPR_X1_BIT 2
`define IPR_T1_BIT 3
`define IPR_S0_BIT 4
`define IPR_T2_BIT 5
`define IPR_TOP_LSB 6
`define IPR_TOP_MSB 7
`define IPR_UNUSED_RD 2'h3
`define IPR_PRIO_RST 6'h00

`endif

// ==== include/ipr_pkg.sv ====
/*
 Types shared by the interrupt priority block: source codes, the grant carried
 to the core and the register bus request. Assumes ipr_map.svh is on the path.
*/
`include "ipr_map.svh"

package ipr_pkg;

    // ------------------------------------------------------------------------
    // Source codes, in polling order
    // ------------------------------------------------------------------------
    typedef enum logic [`IPR_ID_W-1:0] {
        IPR_SRC_X0 = 3'h0,
        IPR_SRC_T0 = 3'h1,
        IPR_SRC_X1 = 3'h2,
        IPR_SRC_T1 = 3'h3,
        IPR_SRC_S0 = 3'h4,
        IPR_SRC_T2 = 3'h5
    } ipr_src_t;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic high;
        ipr_src_t id;
    } ipr_grant_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`IPR_ADDR_W-1:0] addr;
        logic [`IPR_DATA_W-1:0] wdata;
    } ipr_bus_t;

endpackage : ipr_pkg

// ==== hdl/ipr_arbiter.sv ====
/*
 Combinational arbiter: splits pending requests into the two priority levels
 and picks the first in polling order. Assumes requests and gates come from
 logic on the same clock; the caller registers the result.
*/
`timescale 1ns/1ps
`include "ipr_map.svh"

module ipr_arbiter (
    input wire logic [`IPR_NSRC-1:0] req_i, // Pending requests
    input wire logic [`IPR_NSRC-1:0] prio_i, // Priority bits, 1 = high
    input wire logic allow_high_i, // High level may be granted
    input wire logic allow_low_i, // Low level may be granted
    output ipr_pkg::ipr_grant_t grant_o // Chosen request
);
    import ipr_pkg::*;

    logic [`IPR_NSRC-1:0] hi_req;
    logic [`IPR_NSRC-1:0] lo_req;

    // Lowest index wins, so the loop walks downward and the last hit stays
    function automatic logic [`IPR_ID_W-1:0] first_set(input logic [`IPR_NSRC-1:0] v);
        logic [`IPR_ID_W-1:0] idx;
        idx = {`IPR_ID_W{1'b0}};
        for (int i = `IPR_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = `IPR_ID_W'(i);
            end
        end
        return idx;
    endfunction : first_set

    // ------------------------------------------------------------------------
    // Per-source level split
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `IPR_NSRC; g++) begin : g_src
            // A set bit puts its source on the high level
            assign hi_req[g] = req_i[g] & prio_i[g] & allow_high_i; // RULE1 RULE2 RULE3 RULE4
            assign lo_req[g] = req_i[g] & ~prio_i[g] & allow_low_i; // RULE5
        end
    endgenerate

    // High level first, then fixed polling order inside each level
    always_comb begin
        grant_o.valid = (|hi_req) | (|lo_req);
        grant_o.high = |hi_req; // RULE7
        grant_o.id = ipr_src_t'((|hi_req) ? first_set(hi_req) : first_set(lo_req)); // RULE7
    end

endmodule : ipr_arbiter

// ==== hdl/ipr_top.sv ====
/*
 Interrupt priority register and two-level arbitration toward the core.
 Assumes requests, ack and return strobes come from logic on mclk_i, and a
 bus master that never issues read and write together.
*/
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ipr_map.svh"

// How it works
// RULE1: A timer 1 request whose priority bit is 1 competes on the high level.
// RULE2: Bit 2 is a read/write bit putting external interrupt 1 on low (0) or high (1) priority.
// RULE3: Bit 1 is a read/write bit putting timer 0 on low (0) or high (1) priority.
// RULE4: Bit 0 is a read/write bit putting external interrupt 0 on low (0) or high (1) priority.
// RULE5: A timer 1 request whose priority bit is 0 competes on the low level.
// RULE6: The two top bits always read as ones and writes to them are dropped.
// RULE7: A high request may interrupt a low service, and ties in one level go by fixed polling order.
module ipr_top (
    input wire logic mclk_i, // System clock, 50 MHz
    input wire logic arst_n_i, // Asynchronous reset, active low
    input ipr_pkg::ipr_bus_t bus_i, // Register bus request
    output logic [`IPR_DATA_W-1:0] rd_data_o, // Read data, cycle after read
    input wire logic [`IPR_NSRC-1:0] req_i, // Interrupt requests, one per source
    input wire logic ack_i, // Core takes the offered interrupt
    input wire logic reti_i, // Core returns from a service routine
    output ipr_pkg::ipr_grant_t irq_o, // Offered interrupt
    output logic srv_high_o, // High level service in progress
    output logic srv_low_o // Low level service in progress
);
    import ipr_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [`IPR_NSRC-1:0] prio; // Writable part of interrupt_priority
    logic in_srv_high;
    logic in_srv_low;
    ipr_grant_t next_grant;
    logic prio_sel;
    logic take;
    logic next_srv_high;
    logic next_srv_low;

    assign prio_sel = bus_i.addr == `IPR_PRIO_ADDR;
    // An ack only counts while something is being offered
    assign take = ack_i & irq_o.valid;

    // ------------------------------------------------------------------------
    // Priority register
    // ------------------------------------------------------------------------
    // Only the low six bits have storage, so top-bit writes vanish here
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prio <= `IPR_PRIO_RST;
        end else if (bus_i.wr && prio_sel) begin
            prio[`IPR_X0_BIT] <= bus_i.wdata[`IPR_X0_BIT]; // RULE4
            prio[`IPR_T0_BIT] <= bus_i.wdata[`IPR_T0_BIT]; // RULE3
            prio[`IPR_X1_BIT] <= bus_i.wdata[`IPR_X1_BIT]; // RULE2
            prio[`IPR_T1_BIT] <= bus_i.wdata[`IPR_T1_BIT]; // RULE1 RULE5
            prio[`IPR_S0_BIT] <= bus_i.wdata[`IPR_S0_BIT];
            prio[`IPR_T2_BIT] <= bus_i.wdata[`IPR_T2_BIT];
        end
    end

    // Read data live for exactly one cycle; unmapped reads answer zero
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= `IPR_RD_IDLE;
        end else if (bus_i.rd && prio_sel) begin
            rd_data_o <= {`IPR_UNUSED_RD, prio}; // RULE6
        end else begin
            rd_data_o <= `IPR_RD_IDLE;
        end
    end

    // ------------------------------------------------------------------------
    // Service levels
    // ------------------------------------------------------------------------
    // A return closes the innermost level; a take opens its own level.
    // The take is applied last so a level opened in the same cycle survives.
    always_comb begin
        next_srv_high = in_srv_high;
        next_srv_low = in_srv_low;
        if (reti_i) begin
            if (in_srv_high) begin
                next_srv_high = 1'b0;
            end else begin
                next_srv_low = 1'b0;
            end
        end
        if (take) begin
            if (irq_o.high) begin
                next_srv_high = 1'b1; // RULE7
            end else begin
                next_srv_low = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_srv_high <= 1'b0;
            in_srv_low <= 1'b0;
        end else begin
            in_srv_high <= next_srv_high;
            in_srv_low <= next_srv_low;
        end
    end

    // Outputs mirror the level flags from their own flops
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            srv_high_o <= 1'b0;
            srv_low_o <= 1'b0;
        end else begin
            srv_high_o <= next_srv_high;
            srv_low_o <= next_srv_low;
        end
    end

    // ------------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------------
    // Nothing preempts a high service; a low service yields only to high
    ipr_arbiter i_ipr_arbiter (
        .req_i(req_i),
        .prio_i(prio),
        .allow_high_i(!in_srv_high), // RULE7
        .allow_low_i(!in_srv_high && !in_srv_low), // RULE7
        .grant_o(next_grant)
    );

    // Offer is dropped for one cycle after a take, because the level flags
    // it was chosen with are already stale by then
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= '0;
        end else if (take) begin
            irq_o <= '0;
        end else begin
            irq_o <= next_grant; // RULE1 RULE5 RULE7
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    top_reads_ones_a: assert property (bus_i.rd && prio_sel // RULE6
        |=> rd_data_o[`IPR_TOP_MSB:`IPR_TOP_LSB] == `IPR_UNUSED_RD)
        else $error("unused top bits did not read as ones");

    ext1_write_a: assert property (bus_i.wr && prio_sel ##1 bus_i.rd && prio_sel
        |=> rd_data_o[`IPR_X1_BIT] == $past(bus_i.wdata[`IPR_X1_BIT], 2)) // RULE2
        else $error("external interrupt 1 priority bit lost on write");

    tmr0_write_a: assert property (bus_i.wr && prio_sel ##1 bus_i.rd && prio_sel
        |=> rd_data_o[`IPR_T0_BIT] == $past(bus_i.wdata[`IPR_T0_BIT], 2)) // RULE3
        else $error("timer 0 priority bit lost on write");

    ext0_write_a: assert property (bus_i.wr && prio_sel ##1 bus_i.rd && prio_sel
        |=> rd_data_o[`IPR_X0_BIT] == $past(bus_i.wdata[`IPR_X0_BIT], 2)) // RULE4
        else $error("external interrupt 0 priority bit lost on write");

    tmr1_high_a: assert property (irq_o.valid && irq_o.id == IPR_SRC_T1 && $past(prio[`IPR_T1_BIT])
        |-> irq_o.high) // RULE1
        else $error("timer 1 offered low while set high");

    tmr1_low_a: assert property (irq_o.valid && irq_o.id == IPR_SRC_T1 && !$past(prio[`IPR_T1_BIT])
        |-> !irq_o.high) // RULE5
        else $error("timer 1 offered high while set low");

    high_blocks_all_a: assert property (in_srv_high |=> !irq_o.valid) // RULE7
        else $error("offer made during high service");

    low_blocks_low_a: assert property (in_srv_low |=> !(irq_o.valid && !irq_o.high)) // RULE7
        else $error("low offer made during low service");

    poll_order_a: assert property (!in_srv_high && !in_srv_low && !take && !prio[`IPR_X0_BIT]
        && !prio[`IPR_T0_BIT] && req_i[`IPR_X0_BIT] && req_i[`IPR_T0_BIT] && !(|(req_i & prio))
        |=> irq_o.valid && irq_o.id == IPR_SRC_X0) // RULE7
        else $error("polling order not kept on the low level");

    // ------------------------------------------------------------------------
    // Register bus checks
    // ------------------------------------------------------------------------
    // Read data must fall back to idle, so a stale byte is never taken twice
    rd_idle_a: assert property (!(bus_i.rd && prio_sel) |=> rd_data_o == `IPR_RD_IDLE)
        else $error("read data did not return to idle");

    // A write aimed elsewhere must leave the priority bits alone
    stray_write_a: assert property (bus_i.wr && !prio_sel |=> $stable(prio))
        else $error("priority bits changed by a write elsewhere");

    // ------------------------------------------------------------------------
    // Level checks per source
    // ------------------------------------------------------------------------
    // The offer is built from last cycle's bits, hence the past value here
    ext1_level_a: assert property (irq_o.valid && irq_o.id == IPR_SRC_X1 // RULE2
        |-> irq_o.high == $past(prio[`IPR_X1_BIT]))
        else $error("external interrupt 1 offered on the wrong level");

    tmr0_level_a: assert property (irq_o.valid && irq_o.id == IPR_SRC_T0 // RULE3
        |-> irq_o.high == $past(prio[`IPR_T0_BIT]))
        else $error("timer 0 offered on the wrong level");

    ext0_level_a: assert property (irq_o.valid && irq_o.id == IPR_SRC_X0 // RULE4
        |-> irq_o.high == $past(prio[`IPR_X0_BIT]))
        else $error("external interrupt 0 offered on the wrong level");

    // ------------------------------------------------------------------------
    // Service level checks
    // ------------------------------------------------------------------------
    // A pending high request must break into a low service at the next edge
    high_preempts_low_a: assert property (in_srv_low && !in_srv_high && !take && |(req_i & prio) // RULE7
        |=> irq_o.valid && irq_o.high)
        else $error("high request did not break into low service");

    // The offer is withdrawn for one cycle after every take
    take_gap_a: assert property (take |=> !irq_o.valid) // RULE7
        else $error("offer still made right after a take");

    // A take opens the level of the offer it answered, even beside a return
    high_take_opens_a: assert property (take && irq_o.high |=> in_srv_high) // RULE7
        else $error("high take did not open the high level");

    low_take_opens_a: assert property (take && !irq_o.high |=> in_srv_low) // RULE7
        else $error("low take did not open the low level");

    // A return with both levels open closes only the inner one
    reti_inner_a: assert property (reti_i && in_srv_high && in_srv_low && !take // RULE7
        |=> !in_srv_high && in_srv_low)
        else $error("return did not close the innermost level");

    // ------------------------------------------------------------------------
    // Coverage of the main scenarios
    // ------------------------------------------------------------------------
    preempt_c: cover property (in_srv_low && irq_o.valid && irq_o.high);
    nested_ret_c: cover property (in_srv_high && in_srv_low ##1 reti_i ##1 in_srv_low && !in_srv_high);
    write_read_c: cover property (bus_i.wr && prio_sel ##1 bus_i.rd && prio_sel);
    tie_low_c: cover property ($countones(req_i & ~prio) > 1 && !in_srv_low && !in_srv_high);
    high_take_c: cover property (take && irq_o.high);

endmodule : ipr_top

// ==== sim/ipr_core_model.sv ====
/*
 Core-side partner: takes an offered interrupt with a one-cycle ack.
 Assumes the priority block runs on the same clock and reset.
*/
`timescale 1ns/1ps

module ipr_core_model (
    input wire logic mclk_i, // System clock
    input wire logic arst_n_i, // Reset, active low
    input ipr_pkg::ipr_grant_t irq_i, // Offer from the block
    input wire logic take_i, // Accept offers while high
    output logic ack_o // Take pulse toward the block
);
    import ipr_pkg::*;

    // One pulse per live offer; never acks an empty offer
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= take_i && irq_i.valid && !ack_o;
        end
    end
endmodule : ipr_core_model

// ==== sim/ipr_top_tb.sv ====
/*
 Self-checking bench of the interrupt priority block.
 Assumes ipr_map.svh on the include path and the core model beside it.
*/
`timescale 1ns/1ps
`include "ipr_map.svh"

module ipr_top_tb;
    import ipr_pkg::*;

    logic mclk_i, arst_n_i, ack_i, reti_i, take;
    ipr_bus_t bus_i;
    logic [`IPR_DATA_W-1:0] rd_data_o;
    logic [`IPR_NSRC-1:0] req_i;
    ipr_grant_t irq_o;
    logic srv_high_o, srv_low_o;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    ipr_top i_ipr_top (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
        .req_i(req_i), .ack_i(ack_i), .reti_i(reti_i), .irq_o(irq_o), .srv_high_o(srv_high_o),
        .srv_low_o(srv_low_o));
    ipr_core_model i_ipr_core_model (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .irq_i(irq_o),
        .take_i(take), .ack_o(ack_i));

    // ------------------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    // A hang is cut short well past the fewer than one hundred cycles the tests need
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Writes leave the strobe up; the read that always follows drops it
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk_i);
        bus_i <= '0;
        #1 check(rd_data_o, exp);
    endtask : bus_rd

    task automatic offer(input logic [5:0] r, input logic [7:0] exp);
        @(posedge mclk_i);
        req_i <= r;
        @(posedge mclk_i);
        #1 check(8'(irq_o), exp);
    endtask : offer

    task automatic reti_pulse(input logic [7:0] exp);
        @(posedge mclk_i);
        reti_i <= 1'b1;
        @(posedge mclk_i);
        reti_i <= 1'b0;
        #1 check({6'h00, srv_high_o, srv_low_o}, exp);
    endtask : reti_pulse

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    // Reset value, unmapped place, bits 0 to 3 each alone, top bits fixed
    task automatic test_regs();
        bus_rd(8'hB8, 8'hC0);
        bus_wr(8'h00, 8'hFF);
        bus_rd(8'h00, 8'h00);
        bus_rd(8'hB8, 8'hC0);
        for (int b = 0; b < 4; b++) begin
            bus_wr(8'hB8, 8'h01 << b);
            bus_rd(8'hB8, 8'hC0 | (8'h01 << b));
        end
        bus_wr(8'hB8, 8'hFF);
        bus_rd(8'hB8, 8'hFF);
        bus_wr(8'hB8, 8'h00);
        bus_rd(8'hB8, 8'hC0);
        $display("test regs done");
    endtask : test_regs

    // Timer 1 moves between levels as its bit changes
    task automatic test_levels();
        bus_wr(8'hB8, 8'h08);
        bus_rd(8'hB8, 8'hC8);
        offer(6'h09, 8'h1B);
        bus_wr(8'hB8, 8'h00);
        bus_rd(8'hB8, 8'hC0);
        offer(6'h09, 8'h10);
        offer(6'h0E, 8'h11);
        offer(6'h00, 8'h00);
        $display("test levels done");
    endtask : test_levels

    // Low service is opened, then a high request breaks into it
    task automatic test_preempt();
        bus_wr(8'hB8, 8'h04);
        bus_rd(8'hB8, 8'hC4);
        offer(6'h02, 8'h11);
        // Model acks one edge after take, the block takes at the edge after
        @(posedge mclk_i);
        take <= 1'b1;
        repeat (2) @(posedge mclk_i);
        take <= 1'b0;
        req_i <= 6'h00;
        #1 check(8'(irq_o), 8'h00);
        check({7'h00, srv_low_o}, 8'h01);
        offer(6'h03, 8'h00);
        offer(6'h07, 8'h1A);
        @(posedge mclk_i);
        take <= 1'b1;
        repeat (2) @(posedge mclk_i);
        take <= 1'b0;
        req_i <= 6'h00;
        #1 check(8'(irq_o), 8'h00);
        check({6'h00, srv_high_o, srv_low_o}, 8'h03);
        reti_pulse(8'h01);
        reti_pulse(8'h00);
        $display("test preempt done");
    endtask : test_preempt

    // Reset in mid-run clears the offer and the priority bits; the levels, already closed, are checked to stay clear
    task automatic test_reset();
        bus_wr(8'hB8, 8'h3F);
        bus_rd(8'hB8, 8'hFF);
        offer(6'h01, 8'h18);
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        req_i <= 6'h00;
        repeat (3) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        #1 check({1'b0, irq_o, srv_high_o, srv_low_o}, 8'h00);
        bus_rd(8'hB8, 8'hC0);
        $display("test reset done");
    endtask : test_reset

    initial begin
        arst_n_i = 1'b0;
        bus_i = '0;
        req_i = '0;
        reti_i = 1'b0;
        take = 1'b0;
        repeat (3) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        test_regs();
        test_levels();
        test_preempt();
        test_reset();
        final_report();
    end
endmodule : ipr_top_tb
